/* File: src/port_pkg.sv */
/*
  Shared constants and types for the sense-pin port block: register offsets,
  reset values, pad configuration codes, slave addresses and link states.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package port_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CONFIG_A = 8'h73;
  localparam logic [7:0] OFS_CONFIG_B = 8'h74;
  localparam logic [7:0] OFS_LEVEL = 8'h75;
  localparam logic [7:0] OFS_DIRECTION = 8'h76;
  localparam logic [7:0] OFS_ENABLE = 8'h77;
  localparam logic [7:0] OFS_LEVEL_SET = 8'h78;
  localparam logic [7:0] OFS_LEVEL_CLEAR = 8'h79;
  localparam logic [7:0] OFS_LEVEL_FLIP = 8'h7A;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h80;

  // Reset values: every port function off, pins floating
  localparam logic [7:0] RST_PORT_REG = 8'h00;
  localparam logic [7:0] SOFT_RESET_KEY = 8'h63;

  // Pin mapping: register bit 0 is sense pin four
  localparam int PORT_PINS = 8;
  localparam logic [3:0] FIRST_PORT_PIN = 4'h4;

  // Pad configuration codes {bit_a, bit_b}
  localparam logic [1:0] PAD_PLAIN = 2'h0;
  localparam logic [1:0] PAD_UNDEF = 2'h1;
  localparam logic [1:0] PAD_LOW_SIDE = 2'h2;
  localparam logic [1:0] PAD_HIGH_SIDE = 2'h3;

  // Slave addresses by strap: ground, supply, data line, clock line
  localparam logic [6:0] SLAVE_ADDR_GND = 7'h5A;
  localparam logic [6:0] SLAVE_ADDR_VDD = 7'h5B;
  localparam logic [6:0] SLAVE_ADDR_SDA = 7'h5C;
  localparam logic [6:0] SLAVE_ADDR_SCL = 7'h5D;

  localparam logic [2:0] LAST_BIT = 3'h7;

  // Link-side state of the two-wire slave
  typedef enum logic [3:0] {
    LNK_IDLE = 4'b0000,
    LNK_ADDR = 4'b0001,
    LNK_ADDR_ACK = 4'b0010,
    LNK_REG = 4'b0011,
    LNK_REG_ACK = 4'b0100,
    LNK_WDATA = 4'b0101,
    LNK_WDATA_ACK = 4'b0110,
    LNK_RDATA = 4'b0111,
    LNK_RDATA_ACK = 4'b1000
  } link_state_t;

  // One register write carried from the link to the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage : port_pkg

/* File: src/port_ctrl.sv */
/*
  Sense-pin port block: eight pins as GPIO or LED drivers, with a two-wire
  register slave. Register logic runs on core_clk; the serial engine runs on
  the master's clock scl_clk. Assumes the measurement engine supplies the
  electrode configuration byte, a charging level and a conversion-done
  pulse on core_clk.
*/
// Overview of operation
// - Writing 0x63 to 0x80 resets all but link
// - Register bits 7..0 map to sense pins 11..4
// - Port registers writable in stop and run mode
// - Electrode selection overrides port enable on the next core clock
// - After reset every pin floats, all disabled
// - Enable low floats the pin regardless of others
// - Input pads: plain, pulldown, pullup; 01 as 00
// - Output pads: push-pull, low-side, high-side; 01 as 00
// - Enabled outputs drive their level register bit
// - Level changes wait until conversion completes
// - Output pins read back the stored bit
// - Enabled input pins read latched level; writes only store
// - Set, clear, flip registers act on written ones
// - Set, clear, flip read back level register
// - Slave only: clock input, data open-drain
// - Start, address, register, data bytes, stop
// - Slave address chosen by strap pin
`timescale 1ns/100ps
`default_nettype none

module port_ctrl
  import port_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Measurement engine
  input wire logic [7:0] electrode_config_reg,
  input wire logic charging_busy,
  input wire logic adc_done,
  // Address strap, 0 ground, 1 supply, 2 data line, 3 clock line
  input wire logic [1:0] addr_strap,
  // Two-wire link
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Sense pins used as port pins
  input wire logic [PORT_PINS-1:0] pad_in,
  output logic [PORT_PINS-1:0] pad_out,
  output logic [PORT_PINS-1:0] pad_oe,
  output logic [PORT_PINS-1:0] pad_pull_up,
  output logic [PORT_PINS-1:0] pad_pull_down
);

  // Core-side registers
  logic [7:0] config_a_ff, config_b_ff, level_ff, direction_ff, enable_ff;
  logic [7:0] applied_level_ff, pin_sync1_ff, pin_latched_ff;
  logic [7:0] rd_data_ff;
  logic soft_rst_ff, sda_out_ff;
  logic [2:0] wr_sync_ff, rd_sync_ff;
  logic [7:0] sense_sel;
  logic [PORT_PINS-1:0] nxt_out, nxt_oe, nxt_up, nxt_dn;
  logic [PORT_PINS-1:0] out_ff, oe_ff, up_ff, dn_ff;
  logic wr_event, rd_event, port_rst;
  reg_write_t wr_word_ff;

  // Link-side registers
  link_state_t state_ff;
  logic [7:0] shift_ff, tx_ff, ptr_ff;
  logic [2:0] cnt_ff;
  logic smp_ff, rw_ff, sda_oe_ff, start_seen_ff, start_tgl_ff;
  logic wr_tgl_ff, rd_req_ff;
  logic [1:0] lrst_sync_ff, strap_sync1_ff, strap_sync2_ff;
  logic [6:0] my_addr;
  logic [7:0] rx_byte;
  logic link_rst;

  // Read-back view of one register
  function automatic logic [7:0] reg_view(input logic [7:0] addr);
    logic [7:0] view;
    view = 8'h00;
    case (addr)
      OFS_CONFIG_A: view = config_a_ff;
      OFS_CONFIG_B: view = config_b_ff;
      OFS_DIRECTION: view = direction_ff;
      OFS_ENABLE: view = enable_ff;
      // Enabled inputs show the latched pin, others the stored bit
      OFS_LEVEL: view = (enable_ff & ~direction_ff & pin_latched_ff) |
                        (~(enable_ff & ~direction_ff) & level_ff);
      OFS_LEVEL_SET, OFS_LEVEL_CLEAR, OFS_LEVEL_FLIP: view = level_ff;
      default: view = 8'h00;
    endcase
    return view;
  endfunction : reg_view

  // Sense pin selected as electrode by the configured count
  function automatic logic pin_sensing(input logic [3:0] count, input int idx);
    return count > (FIRST_PORT_PIN + 4'(idx));
  endfunction : pin_sensing

  // Core side: events from the link cross by toggles
  assign wr_event = wr_sync_ff[2] ^ wr_sync_ff[1];
  assign rd_event = rd_sync_ff[2] ^ rd_sync_ff[1];
  assign port_rst = sys_rst | soft_rst_ff;

  // Toggle synchronisers; soft reset leaves the link path alone
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_sync_ff <= 3'h0;
      rd_sync_ff <= 3'h0;
    end else begin
      wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_req_ff};
    end
  end

  // Soft reset key, one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_event && wr_word_ff.addr == OFS_SOFT_RESET &&
                     wr_word_ff.data == SOFT_RESET_KEY;
    end
  end

  // Port registers, writable in any engine mode
  always_ff @(posedge core_clk) begin
    if (port_rst) begin
      config_a_ff <= RST_PORT_REG;
      config_b_ff <= RST_PORT_REG;
      level_ff <= RST_PORT_REG;
      direction_ff <= RST_PORT_REG;
      enable_ff <= RST_PORT_REG;
    end else if (wr_event) begin
      case (wr_word_ff.addr)
        OFS_CONFIG_A: config_a_ff <= wr_word_ff.data;
        OFS_CONFIG_B: config_b_ff <= wr_word_ff.data;
        OFS_LEVEL: level_ff <= wr_word_ff.data;
        OFS_DIRECTION: direction_ff <= wr_word_ff.data;
        OFS_ENABLE: enable_ff <= wr_word_ff.data;
        OFS_LEVEL_SET: level_ff <= level_ff | wr_word_ff.data;
        OFS_LEVEL_CLEAR: level_ff <= level_ff & ~wr_word_ff.data;
        OFS_LEVEL_FLIP: level_ff <= level_ff ^ wr_word_ff.data;
        default: level_ff <= level_ff;
      endcase
    end
  end

  // Level reaching the pads waits out electrode charging
  always_ff @(posedge core_clk) begin
    if (port_rst) begin
      applied_level_ff <= RST_PORT_REG;
    end else if (!charging_busy || adc_done) begin
      applied_level_ff <= level_ff;
    end
  end

  // Pin inputs pass two flops before use
  always_ff @(posedge core_clk) begin
    if (port_rst) begin
      pin_sync1_ff <= 8'h00;
      pin_latched_ff <= 8'h00;
    end else begin
      pin_sync1_ff <= pad_in;
      pin_latched_ff <= pin_sync1_ff;
    end
  end

  // Read data for the link, fetched on request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data_ff <= 8'h00;
    end else if (rd_event) begin
      rd_data_ff <= reg_view(ptr_ff);
    end
  end

  // Pad decode per pin; bit i is sense pin i+4
  genvar gi;
  generate
    for (gi = 0; gi < PORT_PINS; gi++) begin : g_pad
      logic [1:0] code;
      logic active;
      assign sense_sel[gi] = pin_sensing(electrode_config_reg[3:0], gi);
      assign code = {config_a_ff[gi], config_b_ff[gi]};
      assign active = enable_ff[gi] & ~sense_sel[gi];
      always_comb begin
        nxt_out[gi] = 1'b0;
        nxt_oe[gi] = 1'b0;
        nxt_up[gi] = 1'b0;
        nxt_dn[gi] = 1'b0;
        if (active && direction_ff[gi]) begin
          case (code)
            PAD_HIGH_SIDE: begin
              nxt_out[gi] = 1'b1;
              nxt_oe[gi] = applied_level_ff[gi];
            end
            PAD_LOW_SIDE: begin
              nxt_out[gi] = 1'b0;
              nxt_oe[gi] = ~applied_level_ff[gi];
            end
            default: begin // Push-pull, undefined code too
              nxt_out[gi] = applied_level_ff[gi];
              nxt_oe[gi] = 1'b1;
            end
          endcase
        end else if (active) begin
          case (code)
            PAD_HIGH_SIDE: nxt_up[gi] = 1'b1;
            PAD_LOW_SIDE: nxt_dn[gi] = 1'b1;
            default: nxt_up[gi] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Pad outputs registered; reset floats everything
  always_ff @(posedge core_clk) begin
    if (port_rst) begin
      out_ff <= '0;
      oe_ff <= '0;
      up_ff <= '0;
      dn_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      up_ff <= nxt_up;
      dn_ff <= nxt_dn;
    end
  end

  // Data line is open-drain: only ever pulled low
  always_ff @(posedge core_clk) begin
    sda_out_ff <= 1'b0;
  end

  assign pad_out = out_ff;
  assign pad_oe = oe_ff;
  assign pad_pull_up = up_ff;
  assign pad_pull_down = dn_ff;
  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;

  // Link side: reset and strap caught on the master's clock
  assign link_rst = lrst_sync_ff[1];
  always_ff @(posedge scl_clk) begin
    lrst_sync_ff <= {lrst_sync_ff[0], sys_rst};
    strap_sync1_ff <= addr_strap;
    strap_sync2_ff <= strap_sync1_ff;
  end

  // Strap selects the slave address
  always_comb begin
    case (strap_sync2_ff)
      2'h0: my_addr = SLAVE_ADDR_GND;
      2'h1: my_addr = SLAVE_ADDR_VDD;
      2'h2: my_addr = SLAVE_ADDR_SDA;
      default: my_addr = SLAVE_ADDR_SCL;
    endcase
  end

  // Start marker: data falling while clock high; also catches stop-start
  always_ff @(negedge sda_in) begin
    if (sys_rst) begin
      start_tgl_ff <= 1'b0;
    end else if (scl_clk) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  // Data bit sampled while the clock is high
  always_ff @(posedge scl_clk) begin
    smp_ff <= sda_in;
  end

  assign rx_byte = {shift_ff[6:0], smp_ff};

  // Serial engine steps on the falling clock, when data may change
  always_ff @(negedge scl_clk) begin
    if (link_rst) begin
      state_ff <= LNK_IDLE;
      sda_oe_ff <= 1'b0;
      cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      wr_tgl_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      start_seen_ff <= start_tgl_ff;
      wr_word_ff <= '0;
    end else if (start_tgl_ff != start_seen_ff) begin
      // Start or repeated start restarts the frame
      start_seen_ff <= start_tgl_ff;
      state_ff <= LNK_ADDR;
      cnt_ff <= 3'h0;
      sda_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        LNK_ADDR, LNK_REG, LNK_WDATA: begin
          shift_ff <= rx_byte;
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == LAST_BIT) begin
            sda_oe_ff <= 1'b1; // Acknowledge by pulling low
            if (state_ff == LNK_ADDR) begin
              rw_ff <= rx_byte[0];
              state_ff <= LNK_ADDR_ACK;
              if (rx_byte[7:1] != my_addr) begin
                sda_oe_ff <= 1'b0;
                state_ff <= LNK_IDLE;
              end
            end else if (state_ff == LNK_REG) begin
              ptr_ff <= rx_byte;
              rd_req_ff <= ~rd_req_ff; // Prefetch for a later read
              state_ff <= LNK_REG_ACK;
            end else begin
              wr_word_ff <= '{addr: ptr_ff, data: rx_byte};
              wr_tgl_ff <= ~wr_tgl_ff;
              ptr_ff <= ptr_ff + 8'h01;
              rd_req_ff <= ~rd_req_ff;
              state_ff <= LNK_WDATA_ACK;
            end
          end
        end
        LNK_ADDR_ACK: begin
          cnt_ff <= 3'h0;
          if (rw_ff) begin
            tx_ff <= {rd_data_ff[6:0], 1'b0};
            sda_oe_ff <= ~rd_data_ff[7];
            ptr_ff <= ptr_ff + 8'h01;
            rd_req_ff <= ~rd_req_ff;
            state_ff <= LNK_RDATA;
          end else begin
            sda_oe_ff <= 1'b0;
            state_ff <= LNK_REG;
          end
        end
        LNK_REG_ACK, LNK_WDATA_ACK: begin
          sda_oe_ff <= 1'b0;
          cnt_ff <= 3'h0;
          state_ff <= LNK_WDATA;
        end
        LNK_RDATA: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == LAST_BIT) begin
            sda_oe_ff <= 1'b0; // Release for the master's answer
            state_ff <= LNK_RDATA_ACK;
          end else begin
            sda_oe_ff <= ~tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
          end
        end
        LNK_RDATA_ACK: begin
          cnt_ff <= 3'h0;
          if (!smp_ff) begin
            // Master wants more: next register follows
            tx_ff <= {rd_data_ff[6:0], 1'b0};
            sda_oe_ff <= ~rd_data_ff[7];
            ptr_ff <= ptr_ff + 8'h01;
            rd_req_ff <= ~rd_req_ff;
            state_ff <= LNK_RDATA;
          end else begin
            sda_oe_ff <= 1'b0;
            state_ff <= LNK_IDLE;
          end
        end
        default: begin
          sda_oe_ff <= 1'b0;
          state_ff <= LNK_IDLE;
        end
      endcase
    end
  end

endmodule : port_ctrl

`default_nettype wire

/* File: verification/port_ctrl_monitor.sv */
/*
  Checker for port_ctrl: pad and link pin relations.
  Assumes it is bound onto port_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module port_ctrl_monitor
  import port_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_clk,
  // Watched inputs
  input wire logic [7:0] electrode_config_reg,
  // Watched outputs
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [PORT_PINS-1:0] pad_oe,
  input wire logic [PORT_PINS-1:0] pad_pull_up,
  input wire logic [PORT_PINS-1:0] pad_pull_down
);
  logic [7:0] sense_mask;
  logic [3:0] scl_hi_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Pins taken by sensing, from the electrode count
  always_comb begin
    for (int i = 0; i < PORT_PINS; i++) begin
      sense_mask[i] = int'(electrode_config_reg[3:0]) > i + 4;
    end
  end
  // Cycles the clock line stood high; a bit phase gives at most two
  always_ff @(posedge core_clk) begin
    if (sys_rst || !scl_clk) begin
      scl_hi_ff <= 4'h0;
    end else if (scl_hi_ff != 4'hF) begin
      scl_hi_ff <= scl_hi_ff + 4'h1;
    end
  end
  chk_reset_float: assert property (disable iff (1'b0) sys_rst [*3] |->
    (pad_oe | pad_pull_up | pad_pull_down) == 8'h00) else $error("pads active in reset");
  chk_pull_excl: assert property ((pad_pull_up & pad_pull_down) == 8'h00)
    else $error("both pulls on");
  chk_pull_undriven: assert property (((pad_pull_up | pad_pull_down) & pad_oe) == 8'h00)
    else $error("pull on a driven pad");
  chk_sense_wins: assert property (((pad_oe | pad_pull_up | pad_pull_down) & $past(sense_mask))
    == 8'h00) else $error("sensed pin still a port");
  chk_sda_drain: assert property (sda_out == 1'b0) else $error("data line driven high");
  chk_sda_steady: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
    else $error("data changed with clock high");
  chk_ack_low: assert property ($rose(sda_oe) |-> !scl_clk) else $error("pull began with clock high");
  chk_bus_idle: assert property (scl_hi_ff > 4'h4 |-> !sda_oe) else $error("data held on idle bus");
endmodule : port_ctrl_monitor
bind port_ctrl port_ctrl_monitor port_ctrl_monitor_i (.core_clk, .sys_rst, .scl_clk,
  .electrode_config_reg, .sda_out, .sda_oe, .pad_oe, .pad_pull_up, .pad_pull_down);
`default_nettype wire

/* File: verification/link_host_model.sv */
/*
  Two-wire bus master model; makes the 160 ns link clock.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module link_host_model (
  // Bus lines
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit; data moves only with the clock low
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #40 sda_low = ~b;
    #40 scl = 1'b1;
    s = sda;
    #80;
  endtask : bit_io
  // Edges for link reset, no start among them
  task automatic idle_edges();
    logic s;
    repeat (3) bit_io(1'b0, s);
    bit_io(1'b1, s);
  endtask : idle_edges
  task automatic start();
    #43 sda_low = 1'b1;
    #40;
  endtask : start
  task automatic stop();
    scl = 1'b0;
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #80;
  endtask : stop
  // Byte out, most significant bit first
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put
  // Byte in; last byte answered with a not-acknowledge
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask : get
endmodule : link_host_model
`default_nettype wire

/* File: verification/port_ctrl_tb_top.sv */
/*
  Bench for port_ctrl: register traffic over the link, pad checks.
  Assumes port_pkg, the host model and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module port_ctrl_tb_top;
  import port_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] electrode_config_reg = 8'h00;
  logic charging_busy = 1'b0;
  logic adc_done = 1'b0;
  logic [7:0] pad_in = 8'h00;
  logic scl, sda_low, sda_out, sda_oe, ak;
  logic [7:0] pad_out, pad_oe, pull_up, pull_dn, lv;
  logic [7:0] rd_q [0:1];
  logic [7:0] ofs [0:2] = '{OFS_LEVEL_SET, OFS_LEVEL_CLEAR, OFS_LEVEL_FLIP};
  logic [7:0] pat [0:2] = '{8'h03, 8'h30, 8'hFF};
  wire logic sda;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  // Pull-up line, pulled low by either party
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  always #20 core_clk = ~core_clk;
  port_ctrl port_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .electrode_config_reg(electrode_config_reg),
    .charging_busy(charging_busy), .adc_done(adc_done), .addr_strap(2'h0), .scl_clk(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pull_up), .pad_pull_down(pull_dn));
  link_host_model link_host_model_i (.scl(scl), .sda_low(sda_low), .sda(sda));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Register write, then a few core cycles for the pads to follow
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    link_host_model_i.start();
    link_host_model_i.put({SLAVE_ADDR_GND, 1'b0}, ak);
    link_host_model_i.put(a, ak);
    link_host_model_i.put(d, ak);
    check("wr ack", 8'h01, {7'h00, ak});
    link_host_model_i.stop();
    repeat (3) @(negedge core_clk);
  endtask : wr
  // Pointer set, stop, fresh start; no repeated start
  task automatic rd(input logic [7:0] a, input int n);
    link_host_model_i.start();
    link_host_model_i.put({SLAVE_ADDR_GND, 1'b0}, ak);
    link_host_model_i.put(a, ak);
    link_host_model_i.stop();
    link_host_model_i.start();
    link_host_model_i.put({SLAVE_ADDR_GND, 1'b1}, ak);
    for (int i = 0; i < n; i++) begin
      link_host_model_i.get(i == n - 1, rd_q[i]);
    end
    link_host_model_i.stop();
  endtask : rd
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Hang guard, far above the few thousand cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    fork
      link_host_model_i.idle_edges();
      begin
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
      end
    join
    // The link's reset synchroniser only clears on bus clock edges
    link_host_model_i.idle_edges();
    repeat (2) @(negedge core_clk);
    check("reset pads", 8'h00, pad_oe | pull_up | pull_dn);
    wr(OFS_ENABLE, 8'hFF);
    wr(OFS_DIRECTION, 8'hFF);
    wr(OFS_LEVEL, 8'hA5);
    check("pp oe", 8'hFF, pad_oe);
    check("pp out", 8'hA5, pad_out);
    charging_busy = 1'b1;
    wr(OFS_LEVEL, 8'h3C);
    check("held out", 8'hA5, pad_out);
    adc_done = 1'b1;
    @(negedge core_clk) adc_done = 1'b0;
    charging_busy = 1'b0;
    @(negedge core_clk);
    check("applied out", 8'h3C, pad_out);
    rd(OFS_LEVEL, 1);
    check("level rd", 8'h3C, rd_q[0]);
    lv = 8'h3C;
    for (int i = 0; i < 3; i++) begin
      wr(ofs[i], pat[i]);
      lv = (i == 0) ? (lv | pat[i]) : (i == 1) ? (lv & ~pat[i]) : (lv ^ pat[i]);
      check("atomic out", lv, pad_out);
      rd(ofs[i], 1);
      check("alias rd", lv, rd_q[0]);
    end
    rd(OFS_LEVEL, 2);
    check("burst 0", 8'hF0, rd_q[0]);
    check("burst 1", 8'hFF, rd_q[1]);
    wr(OFS_CONFIG_A, 8'hFF);
    check("low oe", 8'h0F, pad_oe);
    check("low out", 8'h00, pad_out);
    wr(OFS_CONFIG_B, 8'hFF);
    check("high oe", 8'hF0, pad_oe);
    check("high out", 8'hFF, pad_out);
    wr(OFS_CONFIG_A, 8'h00);
    check("undef out", 8'hF0, pad_out & pad_oe);
    check("undef oe", 8'hFF, pad_oe);
    wr(OFS_DIRECTION, 8'h00);
    check("plain in", 8'h00, pad_oe | pull_up | pull_dn);
    wr(OFS_CONFIG_A, 8'hFF);
    check("pullup", 8'hFF, pull_up);
    wr(OFS_CONFIG_B, 8'h00);
    check("pulldown", 8'hFF, pull_dn & ~pull_up);
    pad_in = 8'h5A;
    wr(OFS_LEVEL, 8'h77);
    rd(OFS_LEVEL, 1);
    check("input rd", 8'h5A, rd_q[0]);
    wr(OFS_DIRECTION, 8'hFF);
    check("stored kept", 8'h88, pad_oe);
    electrode_config_reg = 8'h0A;
    repeat (2) @(negedge core_clk);
    check("sensed", 8'h80, pad_oe);
    electrode_config_reg = 8'h00;
    wr(OFS_ENABLE, 8'h00);
    check("disabled", 8'h00, pad_oe | pull_up | pull_dn);
    link_host_model_i.start();
    link_host_model_i.put({SLAVE_ADDR_VDD, 1'b0}, ak);
    link_host_model_i.stop();
    check("foreign ack", 8'h00, {7'h00, ak});
    rd(8'h50, 1);
    check("unmapped", 8'h00, rd_q[0]);
    // Two-byte write: pointer steps from direction to enable
    @(negedge core_clk);
    link_host_model_i.start();
    link_host_model_i.put({SLAVE_ADDR_GND, 1'b0}, ak);
    link_host_model_i.put(OFS_DIRECTION, ak);
    link_host_model_i.put(8'h0F, ak);
    link_host_model_i.put(8'hF0, ak);
    link_host_model_i.stop();
    rd(OFS_DIRECTION, 2);
    check("wr burst 0", 8'h0F, rd_q[0]);
    check("wr burst 1", 8'hF0, rd_q[1]);
    wr(OFS_ENABLE, 8'hFF);
    wr(OFS_SOFT_RESET, 8'h00);
    check("wrong key", 8'h08, pad_oe);
    wr(OFS_SOFT_RESET, SOFT_RESET_KEY);
    check("soft pads", 8'h00, pad_oe);
    rd(OFS_DIRECTION, 1);
    check("soft dir", 8'h00, rd_q[0]);
    results();
  end
endmodule : port_ctrl_tb_top
`default_nettype wire
